/* File: hw/ibt_top.sv */
/*
  inband loopback code detection, 16-bit buffered error tally and receive
  indication pin selection, with an AXI4-Lite register slave.
  assumes the line data path runs on aclk and strobes one cycle per bit.
*/
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
// Notes on behaviour
// RL1 - code lengths programmable per code, two bits each
// RL2 - eight-bit programmable activate and release patterns
// RL3 - code present while bit errors stay under 1e-2
// RL4 - manual mode: activate seen after 40 ms
// RL5 - manual: release after 40 ms, 30 ms E1
// RL6 - auto mode: both seen after 5.1 s
// RL7 - auto mode starts and ends remote/digital loopback
// RL8 - irq flag on rise or either edge
// RL9 - unmasked inband flag drives low interrupt
// RL10 - 16-bit tally counts selected error source
// RL11 - tx single rail: system violations not counted
// RL12 - tally buffered, mode bit picks auto/manual
// RL13 - auto mode: one-second timer triggers update
// RL14 - each second sets tick flag, maskable interrupt; the code sets the flag only while tally_cfg_r[1] selects auto update
// RL15 - update copies count, clears live counter
// RL16 - software reads holding within next second
// RL17 - full tally plus error sets overflow flag
// RL18 - manual: snapshot bit rising edge updates
// RL19 - software reads holding before next snapshot
// RL20 - indicator replaces rail or clock pin by mode
// RL21 - three-bit selector picks the indication
// RL22 - 000 sync with error dips, 111 loss
// RL23 - high holding is bits 15:8, low 7:0
`timescale 1ns/1ps
`default_nettype none
`include "ibt_defines.svh"

module ibt_ib_det #(
  parameter int unsigned SHORT_CYC  = 1,
  parameter int unsigned E1_CYC     = 1,
  parameter int unsigned AUTO_CYC   = 1,
  parameter bit          IS_RELEASE = 1'b0
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       bit_valid,
  input  wire logic       bit_data,
  input  wire logic       auto_en,
  input  wire logic       e1_mode,
  input  wire logic [7:0] code,
  input  wire logic [1:0] len_sel,
  output logic            seen
);
  import ibt_pkg::*;

  logic [7:0]    hist_r;
  logic [7:0]    win_r;
  logic [7:0]    errs_r;
  logic [31:0]   dur_r;
  logic [31:0]   limit;
  logic [3:0]    len;
  logic [7:0]    lmask;
  logic          miss;
  ibt_ib_state_t st_r;

  // length codes 0..3 give 5..8 bits; 3- and 4-bit codes are set as 6 and 8
  assign len   = 4'd5 + {2'b00, len_sel}; // RL1
  assign lmask = 8'hFF >> (4'd8 - len);
  // a repeating code means each bit equals the one a code length earlier
  assign miss  = bit_data != hist_r[3'(len - 4'd1)];
  assign limit = auto_en ? 32'(AUTO_CYC) : // RL6
                 (IS_RELEASE && e1_mode) ? 32'(E1_CYC) : 32'(SHORT_CYC); // RL5

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hist_r <= 8'h00;
    end else if (bit_valid) begin
      hist_r <= {hist_r[6:0], bit_data};
    end
  end

  // 256-bit hopping window, more than two misses drops the lock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r   <= IB_HUNT;
      win_r  <= 8'h00;
      errs_r <= 8'h00;
    end else if (bit_valid) begin
      unique case (st_r)
        IB_HUNT: begin
          win_r  <= 8'h00;
          errs_r <= 8'h00;
          if ((hist_r & lmask) == (code & lmask)) begin // RL2
            st_r <= IB_LOCK;
          end
        end
        IB_LOCK: begin
          win_r <= win_r + 8'h01;
          if (miss && errs_r >= `IBT_IB_MAXERR) begin // RL3
            st_r <= IB_HUNT;
          end else if (win_r == 8'hFF) begin
            errs_r <= 8'(miss);
          end else if (miss) begin
            errs_r <= errs_r + 8'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dur_r <= 32'h0000_0000;
    end else if (st_r == IB_HUNT) begin
      dur_r <= 32'h0000_0000;
    end else if (dur_r != 32'hFFFF_FFFF) begin
      dur_r <= dur_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen <= 1'b0;
    end else begin
      seen <= (st_r == IB_LOCK) && (dur_r > limit); // RL4
    end
  end

  AST_SEEN_LIMIT: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
    $rose(seen) |-> $past(dur_r) > $past(limit) && $past(st_r) == IB_LOCK)
    else $error("code status set before its qualifying period");
endmodule

module ibt_top #(
  parameter int unsigned SHORT_CYC = `IBT_MS_CYC(`IBT_SHORT_MS),
  parameter int unsigned E1_CYC    = `IBT_MS_CYC(`IBT_E1_MS),
  parameter int unsigned AUTO_CYC  = `IBT_MS_CYC(`IBT_AUTO_MS),
  parameter int unsigned SEC_CYC   = `IBT_MS_CYC(`IBT_SEC_MS)
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [7:0]        s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  input  wire ibt_pkg::ibt_line_t line_in,
  output logic                   remote_lb_en,
  output logic                   digital_lb_en,
  output logic                   irq_n,
  output logic                   rx_indicator_pin,
  output logic                   rx_negative_rail_pin,
  output logic                   rx_recovered_clock_pin
);
  import ibt_pkg::*;

  logic [7:0]  aw_addr_r;
  logic [7:0]  w_data_r;
  logic        w_strb_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic        wr_hit;
  logic        wr_ok;
  logic [31:0] rd_data;
  logic [3:0]  len_r;
  logic [7:0]  act_pat_r;
  logic [7:0]  rel_pat_r;
  logic        auto_lb_r;
  logic [1:0]  ib_flag_r;
  logic [1:0]  ib_mask_r;
  logic        edge_sel_r;
  logic [4:0]  tally_cfg_r;
  logic        tick_flag_r;
  logic        tick_mask_r;
  logic        ovf_flag_r;
  logic        ovf_mask_r;
  logic [2:0]  ind_sel_r;
  logic [4:0]  mode_r;
  logic        act_seen;
  logic        rel_seen;
  logic        act_seen_d_r;
  logic        rel_seen_d_r;
  logic [1:0]  ib_set;
  logic [15:0] live_r;
  logic [15:0] hold_r;
  logic [31:0] sec_r;
  logic        tick_r;
  logic        snap_req;
  logic        update;
  logic        err_evt;
  logic        ind_nxt;

  // mode bits: 0 e1, 1 tx single rail, 2 rx single rail, 3 rx sliced
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `IBT_REG_MODE);
  endfunction

  // write address and data are caught in either order; answer after both
  assign wr_hit = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_ok  = wr_hit && w_strb_r && mapped(aw_addr_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 8'h00;
      w_strb_r      <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `IBT_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r     <= s_axi_awaddr;
        aw_got_r      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r     <= s_axi_wdata[7:0];
        w_strb_r     <= s_axi_wstrb[0];
        w_got_r      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_hit) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_r) ? `IBT_RESP_OKAY : `IBT_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (s_axi_araddr)
      `IBT_REG_IB_LEN:  rd_data[3:0] = len_r;
      `IBT_REG_ACT_PAT: rd_data[7:0] = act_pat_r;
      `IBT_REG_REL_PAT: rd_data[7:0] = rel_pat_r;
      `IBT_REG_LOOP:    rd_data[5:3] = {remote_lb_en, digital_lb_en, auto_lb_r};
      `IBT_REG_STATUS_REG_ONE:   rd_data[1:0] = {act_seen_d_r, rel_seen_d_r};
      `IBT_REG_IRQ_ST1: rd_data[1:0] = ib_flag_r;
      `IBT_REG_IRQ_MK1: rd_data[1:0] = ib_mask_r;
      `IBT_REG_EDGE:    rd_data[0]   = edge_sel_r;
      `IBT_REG_TALLY:   rd_data[4:0] = tally_cfg_r;
      `IBT_REG_HOLD_HI: rd_data[7:0] = hold_r[15:8]; // RL23
      `IBT_REG_HOLD_LO: rd_data[7:0] = hold_r[7:0]; // RL23
      `IBT_REG_TMR_ST:  rd_data[0]   = tick_flag_r;
      `IBT_REG_GCFG:    rd_data[0]   = tick_mask_r;
      `IBT_REG_IRQ_ST2: rd_data[0]   = ovf_flag_r;
      `IBT_REG_IRQ_MK2: rd_data[0]   = ovf_mask_r;
      `IBT_REG_RX_CFG:  rd_data[7:5] = ind_sel_r;
      `IBT_REG_MODE:    rd_data[4:0] = mode_r;
      default:          rd_data      = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `IBT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= mapped(s_axi_araddr) ? `IBT_RESP_OKAY : `IBT_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // plain control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      len_r       <= 4'h0;
      act_pat_r   <= `IBT_BYTE_RST;
      rel_pat_r   <= `IBT_BYTE_RST;
      auto_lb_r   <= 1'b0;
      ib_mask_r   <= 2'b00;
      edge_sel_r  <= 1'b0;
      tally_cfg_r <= 5'h00;
      tick_mask_r <= 1'b0;
      ovf_mask_r  <= 1'b0;
      ind_sel_r   <= 3'h0;
      mode_r      <= 5'h00;
    end else if (wr_ok) begin
      unique case (aw_addr_r)
        `IBT_REG_IB_LEN:  len_r       <= w_data_r[3:0];
        `IBT_REG_ACT_PAT: act_pat_r   <= w_data_r;
        `IBT_REG_REL_PAT: rel_pat_r   <= w_data_r;
        `IBT_REG_LOOP:    auto_lb_r   <= w_data_r[`IBT_AUTO_LB_BIT];
        `IBT_REG_IRQ_MK1: ib_mask_r   <= w_data_r[1:0];
        `IBT_REG_EDGE:    edge_sel_r  <= w_data_r[0];
        `IBT_REG_TALLY:   tally_cfg_r <= w_data_r[4:0];
        `IBT_REG_GCFG:    tick_mask_r <= w_data_r[0];
        `IBT_REG_IRQ_MK2: ovf_mask_r  <= w_data_r[0];
        `IBT_REG_RX_CFG:  ind_sel_r   <= w_data_r[`IBT_IND_LSB +: 3];
        `IBT_REG_MODE:    mode_r      <= w_data_r[4:0];
        default:          len_r       <= len_r;
      endcase
    end
  end

  ibt_ib_det #(
    .SHORT_CYC  (SHORT_CYC),
    .E1_CYC     (E1_CYC),
    .AUTO_CYC   (AUTO_CYC),
    .IS_RELEASE (1'b0)
  ) u_act (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .bit_valid (line_in.bit_valid),
    .bit_data  (line_in.bit_data),
    .auto_en   (auto_lb_r),
    .e1_mode   (mode_r[0]),
    .code      (act_pat_r),
    .len_sel   (len_r[`IBT_ACT_LEN_LSB +: 2]),
    .seen      (act_seen)
  );

  ibt_ib_det #(
    .SHORT_CYC  (SHORT_CYC),
    .E1_CYC     (E1_CYC),
    .AUTO_CYC   (AUTO_CYC),
    .IS_RELEASE (1'b1)
  ) u_rel (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .bit_valid (line_in.bit_valid),
    .bit_data  (line_in.bit_data),
    .auto_en   (auto_lb_r),
    .e1_mode   (mode_r[0]),
    .code      (rel_pat_r),
    .len_sel   (len_r[1:0]),
    .seen      (rel_seen)
  );

  // registered copies form the readable status and give the edge reference
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_seen_d_r <= 1'b0;
      rel_seen_d_r <= 1'b0;
    end else begin
      act_seen_d_r <= act_seen;
      rel_seen_d_r <= rel_seen;
    end
  end

  assign ib_set[1] = act_seen ? !act_seen_d_r : (edge_sel_r && act_seen_d_r); // RL8
  assign ib_set[0] = rel_seen ? !rel_seen_d_r : (edge_sel_r && rel_seen_d_r); // RL8

  // sticky flags: write one clears, a same-cycle set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ib_flag_r   <= 2'b00;
      tick_flag_r <= 1'b0;
      ovf_flag_r  <= 1'b0;
    end else begin
      ib_flag_r <= ib_set | (ib_flag_r &
                   ~((wr_ok && aw_addr_r == `IBT_REG_IRQ_ST1) ? w_data_r[1:0] : 2'b00)); // RL8
      tick_flag_r <= (tick_r && tally_cfg_r[1]) || (tick_flag_r && // RL14
                     !(wr_ok && aw_addr_r == `IBT_REG_TMR_ST && w_data_r[0]));
      ovf_flag_r <= (err_evt && !update && live_r == 16'hFFFF) || (ovf_flag_r && // RL17
                    !(wr_ok && aw_addr_r == `IBT_REG_IRQ_ST2 && w_data_r[0]));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !(|(ib_flag_r & ~ib_mask_r) || (tick_flag_r && !tick_mask_r) || // RL9
                 (ovf_flag_r && !ovf_mask_r)); // RL14
    end
  end

  // qualified codes switch loopback only in automatic mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_lb_en  <= 1'b0;
      digital_lb_en <= 1'b0;
    end else if (auto_lb_r) begin
      if (act_seen && !act_seen_d_r) begin
        remote_lb_en  <= remote_lb_en || !line_in.from_tx; // RL7
        digital_lb_en <= digital_lb_en || line_in.from_tx; // RL7
      end else if (rel_seen && !rel_seen_d_r) begin
        remote_lb_en  <= remote_lb_en && line_in.from_tx; // RL7
        digital_lb_en <= digital_lb_en && !line_in.from_tx; // RL7
      end
    end
  end

  always_comb begin
    unique case (tally_cfg_r[`IBT_SEL_LSB +: 3]) // RL10
      3'h0: err_evt = line_in.line_bipolar_violation;
      3'h1: err_evt = line_in.line_excess_zeros;
      3'h2: err_evt = line_in.line_bipolar_violation || line_in.line_excess_zeros;
      3'h3: err_evt = line_in.system_bipolar_violation && !mode_r[1]; // RL11
      3'h4: err_evt = line_in.system_excess_zeros;
      3'h5: err_evt = (line_in.system_bipolar_violation || // RL11
                       line_in.system_excess_zeros) && !mode_r[1];
      3'h6: err_evt = line_in.pattern_err;
      default: err_evt = 1'b0;
    endcase
  end

  // the second timer runs freely; 32 bits covers any sane SEC_CYC
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_r  <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= sec_r == 32'(SEC_CYC - 1); // RL13
      sec_r  <= (sec_r == 32'(SEC_CYC - 1)) ? 32'h0000_0000 : sec_r + 32'h0000_0001;
    end
  end

  assign snap_req = wr_ok && aw_addr_r == `IBT_REG_TALLY && w_data_r[0] && !tally_cfg_r[0]; // RL18
  assign update   = tally_cfg_r[1] ? tick_r : snap_req; // RL12

  // an error landing on the update cycle opens the new interval, never lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      live_r <= `IBT_HOLD_RST;
      hold_r <= `IBT_HOLD_RST;
    end else if (update) begin
      hold_r <= live_r; // RL15
      live_r <= {15'h0000, err_evt}; // RL15
    end else if (err_evt && live_r != 16'hFFFF) begin
      live_r <= live_r + 16'h0001; // RL10
    end
  end

  always_comb begin
    unique case (ind_sel_r) // RL21
      3'h0: ind_nxt = line_in.pattern_sync && !line_in.pattern_err; // RL22
      3'h1: ind_nxt = line_in.line_ais;
      3'h2: ind_nxt = line_in.pos_slice ^ line_in.neg_slice;
      3'h3: ind_nxt = line_in.rclk;
      3'h4: ind_nxt = line_in.line_excess_zeros;
      3'h5: ind_nxt = line_in.line_bipolar_violation;
      3'h6: ind_nxt = line_in.line_excess_zeros || line_in.line_bipolar_violation;
      3'h7: ind_nxt = line_in.line_los; // RL22
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_indicator_pin       <= 1'b0;
      rx_negative_rail_pin   <= 1'b0;
      rx_recovered_clock_pin <= 1'b0;
    end else begin
      rx_indicator_pin       <= ind_nxt;
      rx_negative_rail_pin   <= mode_r[2] ? ind_nxt : line_in.rx_neg_data; // RL20
      rx_recovered_clock_pin <= mode_r[3] ? ind_nxt : line_in.rclk; // RL20
    end
  end

  AST_IB_FLAG: assert property (@(posedge aclk) disable iff (!aresetn) // RL8
    $rose(act_seen) |=> ib_flag_r[1] [*2])
    else $error("activate flag missed a rising status");
  AST_IRQ_LOW: assert property (@(posedge aclk) disable iff (!aresetn) // RL9
    |(ib_flag_r & ~ib_mask_r) |=> !irq_n)
    else $error("unmasked inband flag did not pull irq_n low");
  AST_SNAP: assert property (@(posedge aclk) disable iff (!aresetn) // RL18
    snap_req && !tally_cfg_r[1] |=> hold_r == $past(live_r) && live_r <= 16'h0001)
    else $error("manual snapshot did not move the count");
  AST_TICK: assert property (@(posedge aclk) disable iff (!aresetn) // RL13
    tick_r && tally_cfg_r[1] |=> tick_flag_r && hold_r == $past(live_r))
    else $error("second expiry did not update the tally");
  AST_OVF: assert property (@(posedge aclk) disable iff (!aresetn) // RL17
    live_r == 16'hFFFF && err_evt && !update |=> ovf_flag_r && live_r == 16'hFFFF)
    else $error("overflow not flagged");
  AST_TX_SR: assert property (@(posedge aclk) disable iff (!aresetn) // RL11
    mode_r[1] && tally_cfg_r[4:2] == 3'h3 && !update |=> $stable(live_r))
    else $error("system violation counted in single rail");
  AST_COUNT: assert property (@(posedge aclk) disable iff (!aresetn) // RL10
    err_evt && !update && live_r != 16'hFFFF |=> live_r == $past(live_r) + 16'h0001)
    else $error("selected error was not counted");
  AST_LOS_PIN: assert property (@(posedge aclk) disable iff (!aresetn) // RL22
    ind_sel_r == 3'h7 |=> rx_indicator_pin == $past(line_in.line_los))
    else $error("indicator does not follow line loss");
  AST_REMOTE_LB: assert property (@(posedge aclk) disable iff (!aresetn) // RL7
    auto_lb_r && $rose(act_seen) && !line_in.from_tx |=> remote_lb_en)
    else $error("remote loopback not started");
endmodule

`default_nettype wire

/* File: shared/ibt_defines.svh */
/*
  register offsets, field positions, reset values and timing counts of the
  inband code detector and error tally block.
  assumes byte addresses on a 32-bit AXI4-Lite bus, one register per word.
*/
`ifndef IBT_DEFINES_SVH
`define IBT_DEFINES_SVH

`define IBT_REG_IB_LEN   8'h00
`define IBT_REG_ACT_PAT  8'h04
`define IBT_REG_REL_PAT  8'h08
`define IBT_REG_LOOP     8'h0C
`define IBT_REG_STATUS_REG_ONE    8'h10
`define IBT_REG_IRQ_ST1  8'h14
`define IBT_REG_IRQ_MK1  8'h18
`define IBT_REG_EDGE     8'h1C
`define IBT_REG_TALLY    8'h20
`define IBT_REG_HOLD_HI  8'h24
`define IBT_REG_HOLD_LO  8'h28
`define IBT_REG_TMR_ST   8'h2C
`define IBT_REG_GCFG     8'h30
`define IBT_REG_IRQ_ST2  8'h34
`define IBT_REG_IRQ_MK2  8'h38
`define IBT_REG_RX_CFG   8'h3C
`define IBT_REG_MODE     8'h40

`define IBT_ACT_LEN_LSB  2
`define IBT_AUTO_LB_BIT  3
`define IBT_SEL_LSB      2
`define IBT_IND_LSB      5

`define IBT_BYTE_RST     8'h00
`define IBT_HOLD_RST     16'h0000
`define IBT_RESP_OKAY    2'b00
`define IBT_RESP_SLVERR  2'b10

`define IBT_CLK_HZ       200000000
`define IBT_SHORT_MS     40
`define IBT_E1_MS        30
`define IBT_AUTO_MS      5100
`define IBT_SEC_MS       1000
`define IBT_MS_CYC(ms)   ((ms) * (`IBT_CLK_HZ / 1000))
`define IBT_IB_MAXERR    8'd2

`endif

/* File: shared/ibt_pkg.sv */
/*
  types shared by the inband code detector and error tally block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package ibt_pkg;

  // line-side inputs, all on aclk; event fields are one-cycle strobes
  typedef struct packed {
    logic bit_valid;
    logic bit_data;
    logic from_tx;
    logic pattern_sync;
    logic pattern_err;
    logic line_ais;
    logic line_los;
    logic line_bipolar_violation;
    logic line_excess_zeros;
    logic system_bipolar_violation;
    logic system_excess_zeros;
    logic pos_slice;
    logic neg_slice;
    logic rclk;
    logic rx_neg_data;
  } ibt_line_t;

  typedef enum logic {IB_HUNT, IB_LOCK} ibt_ib_state_t;

endpackage

/* File: tb/ibt_line_src.sv */
/*
  line data source: repeats an 8-bit code msb first, one bit every four clocks.
  assumes the block samples bit_data only while bit_valid is high.
*/
`timescale 1ns/1ps
`default_nettype none
module ibt_line_src (
  input  wire logic       aclk,
  input  wire logic       en,
  input  wire logic [7:0] code,
  output logic            bit_valid,
  output logic            bit_data
);
  logic [4:0] cnt_r;
  always_ff @(posedge aclk) begin
    cnt_r     <= en ? cnt_r + 5'h01 : 5'h00;
    bit_valid <= en && (cnt_r[1:0] == 2'h3);
    // data toggles between bits so a stray sample never looks like the code
    bit_data  <= (en && cnt_r[1:0] == 2'h3) ? code[3'h7 - cnt_r[4:2]] : cnt_r[0];
  end
endmodule
`default_nettype wire

/* File: tb/inband_code_detect_and_error_tally_bench.sv */
/*
  bench for the inband detector, error tally and indicator pin.
  assumes shortened timer counts and registered axi answers.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ibt_defines.svh"
module inband_code_detect_and_error_tally_bench;
  import ibt_pkg::*;
  logic        aclk, aresetn, awv, awr, wv, wr_rdy, bv, br, arv, arr, rvl, rr;
  logic        rlb, dlb, irq_n, ind, rneg, rclkp, s_en, s_v, s_d;
  logic [7:0]  awa, ara, act;
  logic [31:0] wd, rdata, rv, seed;
  logic [1:0]  bresp, rresp, rp;
  logic [4:0]  ev;
  ibt_line_t   ln, lw;
  int          num_errors, n_compared, cyc;

  ibt_top #(.SHORT_CYC(200), .E1_CYC(150), .AUTO_CYC(1000), .SEC_CYC(500)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rvl), .s_axi_rready(rr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .line_in(lw), .remote_lb_en(rlb),
    .digital_lb_en(dlb), .irq_n(irq_n), .rx_indicator_pin(ind), .rx_negative_rail_pin(rneg),
    .rx_recovered_clock_pin(rclkp));
  ibt_line_src SRC (.aclk(aclk), .en(s_en), .code(act), .bit_valid(s_v), .bit_data(s_d));

  always_comb begin
    lw = ln;
    lw.bit_valid = s_v;
    lw.bit_data = s_d;
    {lw.pattern_err, lw.system_excess_zeros, lw.system_bipolar_violation} = ev[4:2];
    {lw.line_excess_zeros, lw.line_bipolar_violation} = ev[1:0];
  end

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // event index: 0 line bpv, 1 line exz, 2 system bpv, 3 system exz, 4 pattern error
  function automatic int hit(input int s, input int k, input logic tx);
    return (s == 0 && k == 0) || (s == 1 && k == 1) || (s == 2 && k < 2) || (s == 3 && k == 2 && !tx)
        || (s == 4 && k == 3) || (s == 5 && (k == 3 || k == 2) && !tx) || (s == 6 && k == 4);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (!bv);
    chk("bresp", {30'h0, `IBT_RESP_OKAY}, {30'h0, bresp});
    br <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rvl);
    rv = rdata;
    rp = rresp;
    rr <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic tally(input logic [2:0] s, input logic tx);
    int n, k, e;
    e = 0;
    wr(`IBT_REG_MODE, {30'h0, tx, 1'b0});
    wr(`IBT_REG_TALLY, {27'h0, s, 2'h0});
    wr(`IBT_REG_TALLY, {27'h0, s, 2'h1});
    wr(`IBT_REG_TALLY, {27'h0, s, 2'h0});
    n = rnd() % 300;
    repeat (n) begin
      k = rnd() % 5;
      e += hit(s, k, tx);
      ev <= 5'h01 << k;
      @(posedge aclk);
      ev <= 5'h00;
      @(posedge aclk);
    end
    wr(`IBT_REG_TALLY, {27'h0, s, 2'h1});
    rd(`IBT_REG_HOLD_HI);
    chk("hold_high", e >> 8, rv);
    rd(`IBT_REG_HOLD_LO);
    chk("hold_low", e & 32'h0000_00FF, rv);
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ceiling sits well above the roughly 10k cycles the sequence needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      test_done();
    end
  end

  initial begin
    {aresetn, awv, wv, br, arv, rr, s_en} = 7'h00;
    {awa, ara, act, ev, wd} = '0;
    ln = '0;
    seed = 32'h8575_c51b;
    num_errors = 0;
    n_compared = 0;
    cyc = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    ln.pattern_sync <= 1'b1;
    @(posedge aclk);
    rd(8'h44);
    chk("unmapped_resp", {30'h0, `IBT_RESP_SLVERR}, {30'h0, rp});
    for (int i = 0; i < 16; i++) tally(i[2:0], i[3]);
    wr(`IBT_REG_MODE, 32'h0000_000C);
    wr(`IBT_REG_RX_CFG, 32'h0000_00E0);
    for (int i = 0; i < 2; i++) begin
      ln.line_los <= i[0];
      repeat (3) @(posedge aclk);
      chk("rx_neg_pin", {31'h0, i[0]}, {31'h0, rneg});
      chk("rx_ind_pin", {31'h0, i[0]}, {31'h0, ind});
      chk("rx_clk_pin", {31'h0, i[0]}, {31'h0, rclkp});
    end
    // top bit clear keeps the all-ones release code out of the activate stream
    act = {1'b0, 7'(rnd())} | 8'h01;
    wr(`IBT_REG_IB_LEN, 32'h0000_000F);
    wr(`IBT_REG_ACT_PAT, {24'h0, act});
    wr(`IBT_REG_REL_PAT, 32'h0000_00FF);
    s_en <= 1'b1;
    repeat (100) @(posedge aclk);
    rd(`IBT_REG_STATUS_REG_ONE);
    chk("act_seen_early", 32'h0, rv);
    repeat (300) @(posedge aclk);
    rd(`IBT_REG_STATUS_REG_ONE);
    chk("act_seen", 32'h2, rv);
    rd(`IBT_REG_IRQ_ST1);
    chk("act_flag", 32'h2, rv);
    chk("irq_n_on", 32'h0, {31'h0, irq_n});
    wr(`IBT_REG_IRQ_MK1, 32'h0000_0002);
    repeat (3) @(posedge aclk);
    chk("irq_n_masked", 32'h1, {31'h0, irq_n});
    wr(`IBT_REG_IRQ_ST1, 32'h0000_0002);
    s_en <= 1'b0;
    repeat (50) @(posedge aclk);
    // a held lock would carry its age into automatic mode, so start afresh
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(`IBT_REG_IB_LEN, 32'h0000_000F);
    wr(`IBT_REG_ACT_PAT, {24'h0, act});
    wr(`IBT_REG_REL_PAT, 32'h0000_00FF);
    wr(`IBT_REG_IRQ_MK1, 32'h0000_0003);
    wr(`IBT_REG_LOOP, 32'h0000_0008);
    s_en <= 1'b1;
    repeat (700) @(posedge aclk);
    rd(`IBT_REG_STATUS_REG_ONE);
    chk("auto_seen_early", 32'h0, rv);
    repeat (600) @(posedge aclk);
    rd(`IBT_REG_STATUS_REG_ONE);
    chk("auto_seen", 32'h2, rv);
    chk("remote_lb", 32'h1, {31'h0, rlb});
    chk("digital_lb", 32'h0, {31'h0, dlb});
    // all ones is the release code and ends the remote loopback
    act <= 8'hFF;
    repeat (1150) @(posedge aclk);
    rd(`IBT_REG_STATUS_REG_ONE);
    chk("rel_seen", 32'h1, rv & 32'h1);
    chk("remote_lb_off", 32'h0, {31'h0, rlb});
    wr(`IBT_REG_TALLY, 32'h0000_0002);
    repeat (1100) @(posedge aclk);
    rd(`IBT_REG_TMR_ST);
    chk("tick_flag", 32'h1, rv);
    chk("irq_n_tick", 32'h0, {31'h0, irq_n});
    wr(`IBT_REG_GCFG, 32'h0000_0001);
    wr(`IBT_REG_TMR_ST, 32'h0000_0001);
    repeat (3) @(posedge aclk);
    chk("irq_n_tick_masked", 32'h1, {31'h0, irq_n});
    rd(`IBT_REG_HOLD_LO);
    chk("hold_auto", 32'h0, rv);
    test_done();
  end
endmodule
`default_nettype wire
